// file: src/irs_pkg.sv
// Shared constants and state types for the two-wire register link.
// Assumes a single 40 MHz clock in each end and pulled-up open-drain wires.
package irs_pkg;

  // Clock and link rate
  localparam int CLK_FREQ_KHZ  = 40000;
  localparam int LINK_FREQ_KHZ = 400;
  localparam int QUARTER_CYC   = CLK_FREQ_KHZ / (4 * LINK_FREQ_KHZ);

  // Addressing and framing
  localparam logic [6:0] DEV_ADDR   = 7'h60;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_TXBIT = 4'h7;
  localparam logic [7:0] NUM_REGS   = 8'h07;
  localparam logic [7:0] NUM_MODES  = 8'h04;

  // Register reset values, pointer 0 in the low byte
  localparam logic [6:0][7:0] REG_RST = {8'h01, 8'h00, 8'hE0, 8'h9E,
                                         8'hB0, 8'h1E, 8'hB4};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RX    = 3'h1,
    ST_RXACK = 3'h3,
    ST_TX    = 3'h2,
    ST_TXACK = 3'h6
  } irs_dst_t;

  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR  = 2'h1,
    K_DATA = 2'h3
  } irs_kind_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BIT   = 2'h3,
    H_STOP  = 2'h2
  } irs_hst_t;

  typedef enum logic [2:0] {
    G_ADDRW = 3'h0,
    G_PTR   = 3'h1,
    G_WDATA = 3'h3,
    G_ADDRR = 3'h2,
    G_RDATA = 3'h6
  } irs_stage_t;

endpackage : irs_pkg

// file: src/irs_link_if.sv
// Two-wire link between the register target and its bus controller.
// Both lines are pulled up; each party only pulls low via its enable.
`timescale 1ns/1ps
interface irs_link_if;
  logic scl_h_oe;
  logic sda_h_oe;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Wired-AND with pullups
  assign scl = ~scl_h_oe;
  assign sda = ~(sda_h_oe | sda_d_oe);

  modport dev  (input scl, input sda, output sda_d_oe);
  modport host (input sda, output scl_h_oe, output sda_h_oe);
endinterface : irs_link_if

// file: src/irs_dev.sv
// Register target end of the two-wire link, with a small register file.
// Assumes the controller makes every clock pulse; no clock stretching.
`timescale 1ns/1ps
// What this block does
// - Overheat never resets registers or interface
// - One bit per clock, high-phase changes control
// - Nine-clock units, eight bits MSB first
// - Works at clock rates up to 400kHz
// - Both lines idle high between transfers
// - Data falling, clock high starts address
// - Data rising, clock high ends transaction
// - Repeated start behaves like a start
// - Ignore clock after stop or wrong address
// - Controller originates transfers and makes clocks
// - Unlimited bytes, each acknowledged separately
// - Acknowledge received bytes through ninth high
// - Acknowledger holds data low whole pulse
// - Reader acknowledges all but last byte
// - Release data after controller declines byte
// - Match fixed seven-bit address plus direction
// - Write: address, pointer, data, update, stop
// - Acknowledge every pointer value received
// - Store each write byte to registers 0-6, advance pointer
// - Selected mode setting applied at acknowledge
// - Undervoltage on either supply restores defaults
// - Read: pointer, repeated start, read bytes
module irs_dev
  import irs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Link
  irs_link_if.dev         link,
  // Supply and mode pins
  input  wire logic       supply_undervoltage_lockout_in1,
  input  wire logic       supply_undervoltage_lockout_vdd,
  input  wire logic       over_temp,
  input  wire logic [1:0] mode_sel,
  // Applied setting
  output logic      [7:0] mode_setting,
  output logic            mode_update,
  output logic [6:0][7:0] reg_file
);

  typedef struct packed {
    logic            scl_m;
    logic            scl_s;
    logic            scl_p;
    logic            sda_m;
    logic            sda_s;
    logic            sda_p;
    logic [1:0]      uv_m;
    logic [1:0]      uv_s;
    logic [1:0]      mode_m;
    logic [1:0]      mode_s;
    logic [1:0]      mode_p;
    irs_dst_t        st;
    irs_kind_t       kind;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      ptr;
    logic            rw;
    logic            oe;
    logic [6:0][7:0] regs;
    logic [7:0]      setting;
    logic            upd;
  } irs_dstate_t;

  irs_dstate_t s_r;
  irs_dstate_t s_nxt;

  always_comb
  begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] rd;
    rise  = 1'b0;
    fall  = 1'b0;
    start = 1'b0;
    stop  = 1'b0;
    rd    = 8'h00;
    s_nxt = s_r;
    s_nxt.upd    = 1'b0;
    s_nxt.scl_m  = link.scl;
    s_nxt.scl_s  = s_r.scl_m;
    s_nxt.scl_p  = s_r.scl_s;
    s_nxt.sda_m  = link.sda;
    s_nxt.sda_s  = s_r.sda_m;
    s_nxt.sda_p  = s_r.sda_s;
    s_nxt.uv_m   = {supply_undervoltage_lockout_vdd,
                    supply_undervoltage_lockout_in1};
    s_nxt.uv_s   = s_r.uv_m;
    s_nxt.mode_m = mode_sel;
    s_nxt.mode_s = s_r.mode_m;
    s_nxt.mode_p = s_r.mode_s;
    rise  = s_r.scl_s & ~s_r.scl_p;
    fall  = ~s_r.scl_s & s_r.scl_p;
    start = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
    stop  = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;
    if (s_r.ptr < NUM_REGS)
      rd = s_r.regs[s_r.ptr[2:0]];

    if (stop)
    begin
      s_nxt.st = ST_IDLE;
      s_nxt.oe = 1'b0;
    end
    else if (start)
    begin
      s_nxt.st   = ST_RX;
      s_nxt.kind = K_ADDR;
      s_nxt.cnt  = 4'h0;
      s_nxt.oe   = 1'b0;
    end
    else
    begin
      unique case (s_r.st)
        ST_IDLE:
          s_nxt.oe = 1'b0;
        ST_RX:
          if (rise)
          begin
            s_nxt.sh  = {s_r.sh[6:0], s_r.sda_s};
            s_nxt.cnt = 4'(s_r.cnt + 4'h1);
          end
          else if (fall && s_r.cnt == BYTE_BITS)
          begin
            s_nxt.cnt = 4'h0;
            s_nxt.st  = ST_RXACK;
            s_nxt.oe  = 1'b1;
            unique case (s_r.kind)
              K_ADDR:
                if (s_r.sh[7:1] == DEV_ADDR)
                  s_nxt.rw = s_r.sh[0];
                else
                begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.oe = 1'b0;
                end
              K_PTR:
                s_nxt.ptr = s_r.sh;
              K_DATA:
              begin
                if (s_r.ptr < NUM_REGS)
                  s_nxt.regs[s_r.ptr[2:0]] = s_r.sh;
                if (s_r.ptr < NUM_MODES && s_r.ptr[1:0] == s_r.mode_s)
                begin
                  s_nxt.setting = s_r.sh;
                  s_nxt.upd     = 1'b1;
                end
                s_nxt.ptr = 8'(s_r.ptr + 8'h01);
              end
              default:
              begin
                s_nxt.st = ST_IDLE;
                s_nxt.oe = 1'b0;
              end
            endcase
          end
        ST_RXACK:
          if (fall)
          begin
            s_nxt.oe = 1'b0;
            if (s_r.kind == K_ADDR && s_r.rw)
            begin
              s_nxt.sh  = rd;
              s_nxt.ptr = 8'(s_r.ptr + 8'h01);
              s_nxt.oe  = ~rd[7];
              s_nxt.st  = ST_TX;
            end
            else
            begin
              s_nxt.st   = ST_RX;
              s_nxt.kind = (s_r.kind == K_ADDR) ? K_PTR : K_DATA;
            end
          end
        ST_TX:
          if (fall)
          begin
            if (s_r.cnt == LAST_TXBIT)
            begin
              s_nxt.oe  = 1'b0;
              s_nxt.cnt = 4'h0;
              s_nxt.st  = ST_TXACK;
            end
            else
            begin
              s_nxt.sh  = {s_r.sh[6:0], 1'b0};
              s_nxt.oe  = ~s_r.sh[6];
              s_nxt.cnt = 4'(s_r.cnt + 4'h1);
            end
          end
        ST_TXACK:
          if (rise && s_r.sda_s)
            s_nxt.st = ST_IDLE;
          else if (fall)
          begin
            s_nxt.sh  = rd;
            s_nxt.ptr = 8'(s_r.ptr + 8'h01);
            s_nxt.oe  = ~rd[7];
            s_nxt.st  = ST_TX;
          end
        default:
        begin
          s_nxt.st = ST_IDLE;
          s_nxt.oe = 1'b0;
        end
      endcase
    end

    // Mode pins moved: follow the newly selected register
    if (s_r.mode_s != s_r.mode_p)
    begin
      s_nxt.setting = s_nxt.regs[s_r.mode_s];
      s_nxt.upd     = 1'b1;
    end
    if (|s_r.uv_s)
    begin
      s_nxt.regs    = REG_RST;
      s_nxt.setting = REG_RST[s_r.mode_s];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r         <= '0;
      s_r.scl_m   <= 1'b1;
      s_r.scl_s   <= 1'b1;
      s_r.scl_p   <= 1'b1;
      s_r.sda_m   <= 1'b1;
      s_r.sda_s   <= 1'b1;
      s_r.sda_p   <= 1'b1;
      s_r.st      <= ST_IDLE;
      s_r.kind    <= K_ADDR;
      s_r.regs    <= REG_RST;
      s_r.setting <= REG_RST[0];
    end
    else
      s_r <= s_nxt;
  end

  assign link.sda_d_oe = s_r.oe;
  assign mode_setting  = s_r.setting;
  assign mode_update   = s_r.upd;
  assign reg_file      = s_r.regs;

endmodule : irs_dev

// file: src/irs_host.sv
// Bus controller end: makes the serial clock and runs write/read frames.
// Assumes the target does not stretch the clock.
`timescale 1ns/1ps
module irs_host
  import irs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Link
  irs_link_if.host        link,
  // Command
  input  wire logic       req,
  input  wire logic       rd_req,
  input  wire logic [7:0] ptr_in,
  input  wire logic [3:0] len_in,
  input  wire logic [7:0] wdata,
  // Status and data
  output logic            busy,
  output logic            wdata_take,
  output logic      [7:0] rdata,
  output logic            rdata_valid,
  output logic            done,
  output logic            nack_err
);

  typedef struct packed {
    logic       sda_m;
    logic       sda_s;
    irs_hst_t   st;
    irs_stage_t stage;
    logic [1:0] q;
    logic [4:0] tcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [3:0] rem;
    logic       rd;
    logic       ackb;
    logic       scl_oe;
    logic       sda_oe;
    logic [7:0] rdata;
    logic       rvalid;
    logic       take;
    logic       done;
    logic       err;
  } irs_hstate_t;

  irs_hstate_t h_r;
  irs_hstate_t h_nxt;

  always_comb
  begin
    logic tick;
    logic sending;
    tick    = 1'b0;
    sending = 1'b0;
    h_nxt        = h_r;
    h_nxt.sda_m  = link.sda;
    h_nxt.sda_s  = h_r.sda_m;
    h_nxt.rvalid = 1'b0;
    h_nxt.take   = 1'b0;
    h_nxt.done   = 1'b0;
    sending      = (h_r.stage != G_RDATA);
    // Quarter-period enable; 400kHz link from the 40 MHz clock
    if (h_r.st != H_IDLE)
    begin
      tick = (h_r.tcnt == 5'(QUARTER_CYC - 1));
      h_nxt.tcnt = tick ? 5'h0 : 5'(h_r.tcnt + 5'h1);
    end
    if (tick)
      h_nxt.q = 2'(h_r.q + 2'h1);

    unique case (h_r.st)
      H_IDLE:
        if (req)
        begin
          h_nxt.st    = H_START;
          h_nxt.q     = 2'h0;
          h_nxt.tcnt  = 5'h0;
          h_nxt.stage = G_ADDRW;
          h_nxt.sh    = {DEV_ADDR, 1'b0};
          h_nxt.ptr   = ptr_in;
          h_nxt.rem   = (len_in == 4'h0) ? 4'h1 : len_in;
          h_nxt.rd    = rd_req;
          h_nxt.err   = 1'b0;
        end
      H_START:
        if (tick)
          unique case (h_r.q)
            2'h0: h_nxt.sda_oe = 1'b0;
            2'h1: h_nxt.scl_oe = 1'b0;
            2'h2: h_nxt.sda_oe = 1'b1;
            2'h3:
            begin
              h_nxt.scl_oe = 1'b1;
              h_nxt.st     = H_BIT;
              h_nxt.bitn   = 4'h0;
            end
          endcase
      H_BIT:
        if (tick)
          unique case (h_r.q)
            2'h0:
              if (h_r.bitn != BYTE_BITS)
                h_nxt.sda_oe = sending & ~h_r.sh[7];
              else
                h_nxt.sda_oe = ~sending & (h_r.rem != 4'h1);
            2'h1: h_nxt.scl_oe = 1'b0;
            2'h2:
              if (h_r.bitn == BYTE_BITS)
                h_nxt.ackb = ~h_r.sda_s;
              else if (!sending)
                h_nxt.sh = {h_r.sh[6:0], h_r.sda_s};
            2'h3:
            begin
              h_nxt.scl_oe = 1'b1;
              if (h_r.bitn != BYTE_BITS)
              begin
                h_nxt.bitn = 4'(h_r.bitn + 4'h1);
                if (sending)
                  h_nxt.sh = {h_r.sh[6:0], 1'b0};
              end
              else
              begin
                h_nxt.bitn = 4'h0;
                if (sending && !h_r.ackb)
                begin
                  h_nxt.err = 1'b1;
                  h_nxt.st  = H_STOP;
                end
                else
                  unique case (h_r.stage)
                    G_ADDRW:
                    begin
                      h_nxt.stage = G_PTR;
                      h_nxt.sh    = h_r.ptr;
                    end
                    G_PTR:
                      if (h_r.rd)
                      begin
                        h_nxt.stage = G_ADDRR;
                        h_nxt.sh    = {DEV_ADDR, 1'b1};
                        h_nxt.st    = H_START;
                      end
                      else
                      begin
                        h_nxt.stage = G_WDATA;
                        h_nxt.sh    = wdata;
                        h_nxt.take  = 1'b1;
                      end
                    G_WDATA:
                    begin
                      h_nxt.rem = 4'(h_r.rem - 4'h1);
                      if (h_r.rem == 4'h1)
                        h_nxt.st = H_STOP;
                      else
                      begin
                        h_nxt.sh   = wdata;
                        h_nxt.take = 1'b1;
                      end
                    end
                    G_ADDRR:
                      h_nxt.stage = G_RDATA;
                    G_RDATA:
                    begin
                      h_nxt.rdata  = h_r.sh;
                      h_nxt.rvalid = 1'b1;
                      h_nxt.rem    = 4'(h_r.rem - 4'h1);
                      if (h_r.rem == 4'h1)
                        h_nxt.st = H_STOP;
                    end
                    default:
                      h_nxt.st = H_STOP;
                  endcase
              end
            end
          endcase
      H_STOP:
        if (tick)
          unique case (h_r.q)
            2'h0: h_nxt.sda_oe = 1'b1;
            2'h1: h_nxt.scl_oe = 1'b0;
            2'h2:
            begin
              h_nxt.sda_oe = 1'b0;
              h_nxt.st     = H_IDLE;
              h_nxt.done   = 1'b1;
            end
            2'h3: h_nxt.st = H_IDLE;
          endcase
      default:
        h_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      h_r       <= '0;
      h_r.sda_m <= 1'b1;
      h_r.sda_s <= 1'b1;
      h_r.st    <= H_IDLE;
      h_r.stage <= G_ADDRW;
    end
    else
      h_r <= h_nxt;
  end

  assign link.scl_h_oe = h_r.scl_oe;
  assign link.sda_h_oe = h_r.sda_oe;
  assign busy          = (h_r.st != H_IDLE);
  assign wdata_take    = h_r.take;
  assign rdata         = h_r.rdata;
  assign rdata_valid   = h_r.rvalid;
  assign done          = h_r.done;
  assign nack_err      = h_r.err;

endmodule : irs_host

// file: testbench/irs_link_chk.sv
// Concurrent checks on the link joining the two design ends.
// Expects one 40 MHz clock, async low reset and pulled-up wires.
`timescale 1ns/1ps
module irs_link_chk
  import irs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link wires and enables
  input wire logic scl_h_oe,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q, sda_q, act, hit, rd, mute;
  logic [3:0] bc;
  logic [7:0] sh, nbyte, lo_cnt;
  logic       start_ev, stop_ev, ack_ev;

  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign ack_ev   = scl && !scl_q && bc == 4'h8;

  // Small frame tracker; mute marks where the target must stay quiet
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {scl_q, sda_q, mute} <= 3'h7;
      {act, hit, rd} <= 3'h0;
      bc <= 4'h0;
      sh <= 8'h00;
      nbyte <= 8'h00;
      lo_cnt <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      lo_cnt <= scl ? 8'h00 : (lo_cnt == 8'hff ? lo_cnt : lo_cnt + 8'h01);
      if (start_ev)
      begin
        {act, mute} <= 2'h2;
        bc <= 4'h0;
        nbyte <= 8'h00;
      end
      else if (stop_ev)
        {act, mute} <= 2'h1;
      else if (ack_ev)
      begin
        bc <= 4'h0;
        nbyte <= nbyte + 8'h01;
        if (nbyte == 8'h00)
        begin
          rd <= sh[0];
          hit <= sh[7:1] == DEV_ADDR;
          if (sh[7:1] != DEV_ADDR)
            mute <= 1'b1;
        end
        else if (rd && sda)
          mute <= 1'b1;
      end
      else if (scl && !scl_q)
      begin
        bc <= bc + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_addr_ack;
    ack_ev && nbyte == 8'h00 |-> sda_d_oe == (sh[7:1] == DEV_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge wrong");
  property p_wr_ack;
    ack_ev && nbyte != 8'h00 && hit && !rd |-> sda_d_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  property p_rd_release;
    ack_ev && nbyte != 8'h00 && rd |-> !sda_d_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("target drives during controller acknowledge");
  property p_mute;
    mute |-> !sda_d_oe;
  endproperty
  a_mute: assert property (p_mute)
    else $error("target drives data while it should be quiet");
  property p_hold_high;
    scl && scl_q |-> $stable(sda_d_oe);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("target changed data while clock high");
  property p_drive_timing;
    $changed(sda_d_oe) |-> !scl && lo_cnt >= 8'h02 && lo_cnt <= 8'h05;
  endproperty
  a_drive_timing: assert property (p_drive_timing)
    else $error("target data change outside low-phase slot");
  property p_start_quiet;
    start_ev |-> sda_h_oe && !sda_d_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("target active right after start");
  property p_idle_clk;
    !act |-> !scl_h_oe;
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("clock pulled outside a frame");

  c_write_ack: cover property (ack_ev && hit && !rd && nbyte == 8'h02);
  c_read_nack: cover property (ack_ev && rd && sda && nbyte != 8'h00);
  c_rep_start: cover property (start_ev && act);
endmodule : irs_link_chk

// file: testbench/i2c_register_slave_tb.sv
// Bench for both link ends; a second target faces a bench-driven wire pair.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
module i2c_register_slave_tb;
  import irs_pkg::*;
  localparam int WD_CYC = 80000;
  logic            clk, arst_n, req, rd_req, busy, wdata_take;
  logic            rdata_valid, done, nack_err, uv_in1, uv_vdd, over_temp;
  logic            mode_update, mode_update_b;
  logic      [1:0] mode_sel;
  logic      [3:0] len_in;
  logic      [7:0] ptr_in, wdata, rdata, mode_setting, mode_setting_b, a;
  logic [6:0][7:0] reg_file, reg_file_b;
  logic      [7:0] wbuf [8];
  logic      [7:0] rbuf [8];
  int              n_rd, n_mu, n_fail, total_checks;

  irs_link_if link_a ();
  irs_link_if link_b ();
  irs_dev irs_dev_i (.clk(clk), .arst_n(arst_n), .link(link_a.dev),
    .supply_undervoltage_lockout_in1(uv_in1),
    .supply_undervoltage_lockout_vdd(uv_vdd), .over_temp(over_temp),
    .mode_sel(mode_sel), .mode_setting(mode_setting),
    .mode_update(mode_update), .reg_file(reg_file));
  irs_dev irs_dev_b_i (.clk(clk), .arst_n(arst_n), .link(link_b.dev),
    .supply_undervoltage_lockout_in1(uv_in1),
    .supply_undervoltage_lockout_vdd(uv_vdd), .over_temp(over_temp),
    .mode_sel(mode_sel), .mode_setting(mode_setting_b),
    .mode_update(mode_update_b), .reg_file(reg_file_b));
  irs_host irs_host_i (.clk(clk), .arst_n(arst_n), .link(link_a.host),
    .req(req), .rd_req(rd_req), .ptr_in(ptr_in), .len_in(len_in),
    .wdata(wdata), .busy(busy), .wdata_take(wdata_take), .rdata(rdata),
    .rdata_valid(rdata_valid), .done(done), .nack_err(nack_err));
  irs_link_chk chk_i (.clk(clk), .arst_n(arst_n),
    .scl_h_oe(link_a.scl_h_oe), .sda_h_oe(link_a.sda_h_oe),
    .sda_d_oe(link_a.sda_d_oe), .scl(link_a.scl), .sda(link_a.sda));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One controller frame; next write byte offered the cycle after a take
  task automatic host_xfer(input logic r, input logic [7:0] p,
                           input logic [3:0] n);
    int k, nt;
    logic upd;
    k = 0; nt = 0; upd = 1'b0; n_rd = 0; n_mu = 0;
    rd_req = r; ptr_in = p; len_in = n; wdata = wbuf[0]; req = 1'b1;
    @(posedge clk);
    #1 req = 1'b0;
    chk("busy in frame", 8'h01, {7'h00, busy});
    while (k < 20000 && done !== 1'b1)
    begin
      @(posedge clk);
      #1 k++;
      if (upd)
        wdata = wbuf[nt[2:0]];
      upd = wdata_take === 1'b1;
      if (upd)
        nt++;
      if (rdata_valid === 1'b1)
      begin
        rbuf[n_rd[2:0]] = rdata;
        n_rd++;
      end
      if (mode_update === 1'b1)
        n_mu++;
    end
    chk("frame done", 8'h01, {7'h00, done});
    chk("busy after frame", 8'h00, {7'h00, busy});
    chk("nack flag", 8'h00, {7'h00, nack_err});
  endtask : host_xfer

  task automatic bb_q;
    repeat (QUARTER_CYC) @(posedge clk);
    #1;
  endtask : bb_q

  task automatic bb_bit(input logic b, output logic seen);
    link_b.sda_h_oe = ~b;
    bb_q;
    link_b.scl_h_oe = 1'b0;
    bb_q;
    seen = link_b.sda;
    bb_q;
    link_b.scl_h_oe = 1'b1;
    bb_q;
  endtask : bb_bit

  task automatic bb_byte(input logic [7:0] v, output logic [7:0] ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bb_bit(v[i], s);
    bb_bit(1'b1, s);
    ack = {7'h00, ~s};
  endtask : bb_byte

  // Works from idle and as a repeated start with the clock low
  task automatic bb_start;
    link_b.sda_h_oe = 1'b0;
    bb_q;
    link_b.scl_h_oe = 1'b0;
    bb_q;
    link_b.sda_h_oe = 1'b1;
    bb_q;
    link_b.scl_h_oe = 1'b1;
    bb_q;
  endtask : bb_start

  task automatic bb_stop;
    link_b.sda_h_oe = 1'b1;
    bb_q;
    link_b.scl_h_oe = 1'b0;
    bb_q;
    link_b.sda_h_oe = 1'b0;
    bb_q;
  endtask : bb_stop

  task automatic sc_defaults;
    for (int i = 0; i < 7; i++)
      chk("default", REG_RST[i], reg_file[i]);
    chk("mode after reset", REG_RST[1], mode_setting);
  endtask : sc_defaults

  task automatic sc_writes;
    wbuf[0] = 8'h5a;
    host_xfer(1'b0, 8'h01, 4'h1);
    chk("single write", 8'h5a, reg_file[1]);
    chk("mode applied", 8'h5a, mode_setting);
    chk("mode pulses", 8'h01, n_mu[7:0]);
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00};
    host_xfer(1'b0, 8'h04, 4'h4);
    for (int i = 4; i < 7; i++)
      chk("burst write", wbuf[i - 4], reg_file[i]);
    chk("no wrap write", REG_RST[0], reg_file[0]);
    chk("other mode quiet", 8'h00, n_mu[7:0]);
    // Mode pins move: setting follows the newly selected register
    mode_sel = 2'h0;
    repeat (10) @(posedge clk);
    #1 chk("mode switch", REG_RST[0], mode_setting);
    mode_sel = 2'h1;
    repeat (10) @(posedge clk);
    #1 chk("mode switch back", 8'h5a, mode_setting);
  endtask : sc_writes

  task automatic sc_reads;
    over_temp = 1'b1;
    host_xfer(1'b1, 8'h04, 4'h4);
    chk("read count", 8'h04, n_rd[7:0]);
    for (int i = 0; i < 3; i++)
      chk("burst read", wbuf[i], rbuf[i]);
    chk("unmapped read", 8'h00, rbuf[3]);
    host_xfer(1'b1, 8'h01, 4'h1);
    chk("single read", 8'h5a, rbuf[0]);
    over_temp = 1'b0;
  endtask : sc_reads

  task automatic sc_supply_undervoltage_lockout;
    for (int j = 0; j < 2; j++)
    begin
      wbuf[0] = 8'ha5;
      host_xfer(1'b0, 8'h01, 4'h1);
      {uv_vdd, uv_in1} = j[0] ? 2'h2 : 2'h1;
      repeat (10) @(posedge clk);
      #1 {uv_vdd, uv_in1} = 2'h0;
      repeat (10) @(posedge clk);
      #1 chk("supply_undervoltage_lockout reg", REG_RST[1], reg_file[1]);
      chk("supply_undervoltage_lockout burst reg", REG_RST[4], reg_file[4]);
      chk("supply_undervoltage_lockout mode", REG_RST[1], mode_setting);
    end
  endtask : sc_supply_undervoltage_lockout

  task automatic sc_bad_addr;
    bb_start;
    bb_byte(8'hc2, a);
    chk("foreign addr ack", 8'h00, a);
    bb_byte(8'h00, a);
    chk("ack after mismatch", 8'h00, a);
    bb_byte(8'hff, a);
    bb_stop;
    bb_byte(8'hc0, a);
    chk("ack after stop", 8'h00, a);
    link_b.scl_h_oe = 1'b0;
    bb_q;
    chk("no write", REG_RST[0], reg_file_b[0]);
  endtask : sc_bad_addr

  task automatic sc_rep_start;
    bb_start;
    bb_byte(8'hc0, a);
    chk("own addr ack", 8'h01, a);
    bb_byte(8'h33, a);
    chk("odd pointer ack", 8'h01, a);
    bb_start;
    bb_byte(8'hc0, a);
    chk("restart addr ack", 8'h01, a);
    bb_byte(8'h02, a);
    bb_byte(8'h77, a);
    chk("data ack", 8'h01, a);
    bb_stop;
    bb_q;
    chk("restart write", 8'h77, reg_file_b[2]);
  endtask : sc_rep_start

  initial
  begin
    n_fail = 0; total_checks = 0; arst_n = 1'b0;
    req = 1'b0; rd_req = 1'b0; ptr_in = 8'h00; len_in = 4'h0;
    wdata = 8'h00; uv_in1 = 1'b0; uv_vdd = 1'b0; over_temp = 1'b0;
    mode_sel = 2'h1; link_b.scl_h_oe = 1'b0; link_b.sda_h_oe = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1 sc_defaults;
    sc_writes;
    sc_reads;
    sc_supply_undervoltage_lockout;
    sc_bad_addr;
    sc_rep_start;
    tally_and_finish;
  end

  initial
  begin
    repeat (WD_CYC) @(posedge clk);
    n_fail++;
    $display("BAD watchdog expected finish seen hang");
    tally_and_finish;
  end
endmodule : i2c_register_slave_tb
